// ---- ipr_pkg.sv ----
/*
 * Constants, register map and state encodings for the input pin remap select block.
 * Assumes one 200 MHz clock, a synchronous active-high reset and a 32-bit classic
 * Wishbone slave port; every file refers to these names as ipr_pkg::name.
 */
package ipr_pkg;

    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 8;
    localparam int NUM_SEL = 16;
    localparam int NUM_INSEL_REGS = 9;
    localparam int NUM_PINS = 64;

    // Codes at or above this limit name no pin
    localparam logic [7:0] PIN_LIMIT = 8'h40;
    localparam logic INACTIVE_LEVEL = 1'b0;

    // Byte addresses on the bus
    localparam logic [7:0] OFS_LOCK_CTRL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INSEL_BASE = 8'h20;
    localparam logic [7:0] OFS_INSEL_LAST = 8'h40;

    localparam int LOCK_BIT = 11;
    localparam int STATUS_ARMED_BIT = 0;
    localparam int STATUS_LOCK_BIT = 1;
    localparam logic RST_LOCK = 1'b0;
    localparam logic [7:0] RST_SELECTOR = 8'h00;
    localparam logic [15:0] RST_REG16 = 16'h0000;

    // Two key words written back to back arm one lock register write
    localparam logic [15:0] UNLOCK_KEY_FIRST = 16'h5A3C;
    localparam logic [15:0] UNLOCK_KEY_SECOND = 16'hC3A5;
    localparam logic [5:0] UNLOCK_WINDOW_CYC = 6'h20;

    // Which select register and which byte holds each selector
    localparam logic [3:0] SEL_REG [NUM_SEL] = '{
        4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
        4'h7, 4'h8, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8
    };
    localparam logic SEL_HI [NUM_SEL] = '{
        1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0
    };

    typedef enum logic [1:0] {
        UNLK_IDLE = 2'b00,
        UNLK_FIRST = 2'b01,
        UNLK_ARMED = 2'b10
    } ipr_unlock_state_t;

endpackage

// ---- ipr_pin_sel.sv ----
/*
 * One selector lane: picks a remappable pin by code and registers it.
 * Assumes pin inputs are already synchronous to clk_i.
 */
`timescale 1ns/1ps
module ipr_pin_sel #(
    parameter int NUM_PINS = 64
) (
    input wire logic clk_i,                     // System clock
    input wire logic rst_i,                     // Synchronous reset, active high
    input wire logic [7:0] code_i,              // Selector code
    input wire logic [NUM_PINS-1:0] pins_i,     // Remappable pins
    output logic route_o                        // Routed peripheral input
);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_o <= ipr_pkg::INACTIVE_LEVEL;
        end else if (code_i < ipr_pkg::PIN_LIMIT) begin
            route_o <= pins_i[code_i[5:0]];
        end else begin
            route_o <= ipr_pkg::INACTIVE_LEVEL;
        end
    end

endmodule

// ---- ipr_top.sv ----
/*
 * Input pin remap select: selector registers, remap lock with unlock sequence,
 * and sixteen registered pin selectors feeding peripheral inputs.
 * Assumes a classic Wishbone master on the register port and pins synchronous
 * to clk_i; the 16-bit registers sit in the low half of each 32-bit word.
 */
`timescale 1ns/1ps
module ipr_top (
    input wire logic clk_i,                                 // System clock, 200 MHz
    input wire logic rst_i,                                 // Synchronous reset, active high
    input wire logic wb_cyc_i,                              // Bus cycle
    input wire logic wb_stb_i,                              // Strobe
    input wire logic wb_we_i,                               // Write enable
    input wire logic [ipr_pkg::ADR_W-1:0] wb_adr_i,         // Byte address
    input wire logic [3:0] wb_sel_i,                        // Byte lanes
    input wire logic [ipr_pkg::DAT_W-1:0] wb_dat_i,         // Write data
    output logic [ipr_pkg::DAT_W-1:0] wb_dat_o,             // Read data
    output logic wb_ack_o,                                  // Acknowledge
    input wire logic [ipr_pkg::NUM_PINS-1:0] remappable_pin_i, // Remappable pins
    output logic remap_lock_o,                              // Lock bit state
    output logic unlock_armed_o,                            // Lock write armed
    output logic ext_irq_one_o,                             // External interrupt one
    output logic ext_irq_two_o,                             // External interrupt two
    output logic ext_irq_three_o,                           // External interrupt three
    output logic timer_one_ext_clock_o,                     // Timer one external clock
    output logic ccp_capture_in_one_o,                      // Capture input one
    output logic ccp_capture_in_two_o,                      // Capture input two
    output logic ccp_capture_in_three_o,                    // Capture input three
    output logic ccp_capture_in_four_o,                     // Capture input four
    output logic ccp_capture_in_five_o,                     // Capture input five
    output logic ccp_capture_in_six_o,                      // Capture input six
    output logic ccp_timer_clk_one_o,                       // Timer clock input one
    output logic ccp_timer_clk_two_o,                       // Timer clock input two
    output logic ccp_timer_clk_three_o,                     // Timer clock input three
    output logic ccp_timer_clk_four_o,                      // Timer clock input four
    output logic ccp_timer_clk_five_o,                      // Timer clock input five
    output logic ccp_timer_clk_six_o                        // Timer clock input six
);

    logic bus_req;
    logic commit;
    logic wr_commit;
    logic hit_lock;
    logic hit_key;
    logic hit_status;
    logic hit_insel;
    logic [7:0] insel_ofs;
    logic [3:0] insel_idx;
    logic [15:0] wr_half;
    logic [15:0] rd_half;
    logic [15:0] insel_rd [ipr_pkg::NUM_INSEL_REGS];
    logic lock_reg;
    logic [7:0] sel_reg [ipr_pkg::NUM_SEL];
    logic [ipr_pkg::NUM_SEL-1:0] route;
    ipr_pkg::ipr_unlock_state_t unlk_reg;
    ipr_pkg::ipr_unlock_state_t unlk_next;
    logic [5:0] window_reg;

    // Bus handshake

    assign bus_req = wb_cyc_i & wb_stb_i;
    // A request takes effect only at the edge where the master sees ack high
    assign commit = bus_req & wb_ack_o;
    assign wr_commit = commit & wb_we_i;
    assign wr_half = wb_dat_i[15:0];

    // Address decode

    assign insel_ofs = wb_adr_i - ipr_pkg::OFS_INSEL_BASE;
    assign insel_idx = insel_ofs[5:2];
    assign hit_lock = (wb_adr_i == ipr_pkg::OFS_LOCK_CTRL);
    assign hit_key = (wb_adr_i == ipr_pkg::OFS_UNLOCK_KEY);
    assign hit_status = (wb_adr_i == ipr_pkg::OFS_STATUS);
    assign hit_insel = (wb_adr_i >= ipr_pkg::OFS_INSEL_BASE)
        && (wb_adr_i <= ipr_pkg::OFS_INSEL_LAST)
        && (wb_adr_i[1:0] == 2'b00);

    // Ack rises one cycle after the request and drops the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // Unlock sequence

    always_comb begin
        unlk_next = unlk_reg;
        case (unlk_reg)
            ipr_pkg::UNLK_IDLE: begin
                if (wr_commit && hit_key && (wr_half == ipr_pkg::UNLOCK_KEY_FIRST)) begin
                    unlk_next = ipr_pkg::UNLK_FIRST;
                end
            end
            ipr_pkg::UNLK_FIRST: begin
                // Second key must be the very next write, any other write restarts
                if (wr_commit) begin
                    if (hit_key && (wr_half == ipr_pkg::UNLOCK_KEY_SECOND)) begin
                        unlk_next = ipr_pkg::UNLK_ARMED;
                    end else begin
                        unlk_next = ipr_pkg::UNLK_IDLE;
                    end
                end
            end
            ipr_pkg::UNLK_ARMED: begin
                // One write of any kind spends the arming; so does the window
                if (wr_commit || (window_reg == 6'h00)) begin
                    unlk_next = ipr_pkg::UNLK_IDLE;
                end
            end
            default: begin
                unlk_next = ipr_pkg::UNLK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlk_reg <= ipr_pkg::UNLK_IDLE;
        end else begin
            unlk_reg <= unlk_next;
        end
    end

    // Arming lapses after a fixed window so a stray write later cannot unlock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            window_reg <= 6'h00;
        end else if (unlk_next == ipr_pkg::UNLK_ARMED && unlk_reg != ipr_pkg::UNLK_ARMED) begin
            window_reg <= ipr_pkg::UNLOCK_WINDOW_CYC;
        end else if (window_reg != 6'h00) begin
            window_reg <= window_reg - 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            unlock_armed_o <= 1'b0;
        end else begin
            unlock_armed_o <= (unlk_next == ipr_pkg::UNLK_ARMED);
        end
    end

    // Lock register

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_reg <= ipr_pkg::RST_LOCK;
        end else if (wr_commit && hit_lock && wb_sel_i[1]
            && (unlk_reg == ipr_pkg::UNLK_ARMED)) begin
            // Only bit 11 has storage; the rest of the word is dropped
            lock_reg <= wr_half[ipr_pkg::LOCK_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remap_lock_o <= ipr_pkg::RST_LOCK;
        end else begin
            remap_lock_o <= lock_reg;
        end
    end

    // Selector storage

    genvar gi;
    generate
        for (gi = 0; gi < ipr_pkg::NUM_SEL; gi++) begin : g_sel
            // Each selector knows its own register and byte half
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sel_reg[gi] <= ipr_pkg::RST_SELECTOR;
                end else if (wr_commit && hit_insel && !lock_reg
                    && insel_idx == ipr_pkg::SEL_REG[gi]) begin
                    if (ipr_pkg::SEL_HI[gi] && wb_sel_i[1]) begin
                        sel_reg[gi] <= wr_half[15:8];
                    end else if (!ipr_pkg::SEL_HI[gi] && wb_sel_i[0]) begin
                        sel_reg[gi] <= wr_half[7:0];
                    end
                end
            end

            ipr_pin_sel #(
                .NUM_PINS(ipr_pkg::NUM_PINS)
            ) u_pin_sel (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .code_i(sel_reg[gi]),
                .pins_i(remappable_pin_i),
                .route_o(route[gi])
            );
        end
    endgenerate

    // Readback view of the select registers

    // Unimplemented low bytes of registers 0 and 2 have no selector and read zero
    always_comb begin
        for (int r = 0; r < ipr_pkg::NUM_INSEL_REGS; r++) begin
            insel_rd[r] = ipr_pkg::RST_REG16;
        end
        for (int s = 0; s < ipr_pkg::NUM_SEL; s++) begin
            if (ipr_pkg::SEL_HI[s]) begin
                insel_rd[ipr_pkg::SEL_REG[s]][15:8] = sel_reg[s];
            end else begin
                insel_rd[ipr_pkg::SEL_REG[s]][7:0] = sel_reg[s];
            end
        end
    end

    always_comb begin
        rd_half = ipr_pkg::RST_REG16;
        if (hit_lock) begin
            rd_half[ipr_pkg::LOCK_BIT] = lock_reg;
        end else if (hit_status) begin
            rd_half[ipr_pkg::STATUS_ARMED_BIT] = (unlk_reg == ipr_pkg::UNLK_ARMED);
            rd_half[ipr_pkg::STATUS_LOCK_BIT] = lock_reg;
        end else if (hit_insel) begin
            rd_half = insel_rd[insel_idx];
        end
    end

    // Read data is loaded with ack and cleared otherwise; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= {16'h0000, rd_half};
        end else begin
            wb_dat_o <= '0;
        end
    end

    // Peripheral inputs, each straight from its selector lane flip-flop

    assign ext_irq_one_o = route[0];
    assign ext_irq_two_o = route[1];
    assign ext_irq_three_o = route[2];
    assign timer_one_ext_clock_o = route[3];
    assign ccp_capture_in_one_o = route[4];
    assign ccp_capture_in_two_o = route[5];
    assign ccp_capture_in_three_o = route[6];
    assign ccp_capture_in_four_o = route[7];
    assign ccp_capture_in_five_o = route[8];
    assign ccp_capture_in_six_o = route[9];
    assign ccp_timer_clk_one_o = route[10];
    assign ccp_timer_clk_two_o = route[11];
    assign ccp_timer_clk_three_o = route[12];
    assign ccp_timer_clk_four_o = route[13];
    assign ccp_timer_clk_five_o = route[14];
    assign ccp_timer_clk_six_o = route[15];

endmodule

// ---- ipr_monitor.sv ----
/*
 * Checker for the input pin remap select block: bus timing, lock behaviour,
 * register read-back layout and pin routing.
 * Assumes it is bound to ipr_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module ipr_monitor (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [ipr_pkg::ADR_W-1:0] wb_adr_i, // Address
    input wire logic [ipr_pkg::DAT_W-1:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic [ipr_pkg::NUM_PINS-1:0] remappable_pin_i, // Pins
    input wire logic remap_lock_o, // Lock state
    input wire logic unlock_armed_o, // Armed
    input wire logic ext_irq_one_o, // Irq one
    input wire logic ext_irq_two_o, // Irq two
    input wire logic ext_irq_three_o, // Irq three
    input wire logic timer_one_ext_clock_o, // Timer one clock
    input wire logic ccp_capture_in_one_o, // Capture one
    input wire logic ccp_timer_clk_one_o // Timer clock one
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    function automatic logic pick(input logic [7:0] c, input logic [63:0] p);
        return (c < 8'h40) ? p[c[5:0]] : 1'b0;
    endfunction

    sequence s_read(logic [7:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    // Routing is only comparable while the pins held still for a cycle
    sequence s_read_steady(logic [7:0] a);
        s_read(a) ##0 remappable_pin_i == $past(remappable_pin_i);
    endsequence

    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_reset_clear;
        $fell(rst_i) |-> !remap_lock_o && !unlock_armed_o && !wb_ack_o && !ext_irq_one_o
            && !ext_irq_two_o && !ext_irq_three_o && !timer_one_ext_clock_o;
    endproperty
    property p_lock_write;
        $changed(remap_lock_o) |-> $past(wb_ack_o && wb_we_i
            && wb_adr_i == ipr_pkg::OFS_LOCK_CTRL, 2);
    endproperty
    property p_lock_armed;
        $changed(remap_lock_o) |-> $past(unlock_armed_o, 2);
    endproperty
    property p_lock_read;
        s_read(ipr_pkg::OFS_LOCK_CTRL) |-> wb_dat_o[15:12] == 4'h0 && wb_dat_o[10:0] == 11'h000;
    endproperty
    property p_sel0;
        s_read_steady(ipr_pkg::OFS_INSEL_BASE) |-> wb_dat_o[7:0] == 8'h00
            && ext_irq_one_o == pick(wb_dat_o[15:8], remappable_pin_i);
    endproperty
    property p_sel1;
        s_read_steady(ipr_pkg::OFS_INSEL_BASE + 8'h04) |->
            ext_irq_three_o == pick(wb_dat_o[15:8], remappable_pin_i)
            && ext_irq_two_o == pick(wb_dat_o[7:0], remappable_pin_i);
    endproperty
    property p_sel2;
        s_read_steady(ipr_pkg::OFS_INSEL_BASE + 8'h08) |-> wb_dat_o[7:0] == 8'h00
            && timer_one_ext_clock_o == pick(wb_dat_o[15:8], remappable_pin_i);
    endproperty
    property p_sel3;
        s_read_steady(ipr_pkg::OFS_INSEL_BASE + 8'h0C) |->
            ccp_capture_in_one_o == pick(wb_dat_o[15:8], remappable_pin_i)
            && ccp_timer_clk_one_o == pick(wb_dat_o[7:0], remappable_pin_i);
    endproperty

    a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
    a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
    a_lock_write: assert property (p_lock_write) else $error("lock moved without write");
    a_lock_armed: assert property (p_lock_armed) else $error("lock moved unarmed");
    a_lock_read: assert property (p_lock_read) else $error("lock spare bits set");
    a_sel0: assert property (p_sel0) else $error("select 0 mismatch");
    a_sel1: assert property (p_sel1) else $error("select 1 mismatch");
    a_sel2: assert property (p_sel2) else $error("select 2 mismatch");
    a_sel3: assert property (p_sel3) else $error("select 3 mismatch");
endmodule

bind ipr_top ipr_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .remappable_pin_i(remappable_pin_i), .remap_lock_o(remap_lock_o),
    .unlock_armed_o(unlock_armed_o), .ext_irq_one_o(ext_irq_one_o),
    .ext_irq_two_o(ext_irq_two_o), .ext_irq_three_o(ext_irq_three_o),
    .timer_one_ext_clock_o(timer_one_ext_clock_o),
    .ccp_capture_in_one_o(ccp_capture_in_one_o), .ccp_timer_clk_one_o(ccp_timer_clk_one_o));

// ---- tb.sv ----
/*
 * Self-checking bench for ipr_top: reset values, selector layout and routing,
 * lock and unlock handling, unmapped reads.
 * Assumes the checker file is compiled alongside and binds itself.
 */
`timescale 1ns/1ps
module tb;
    localparam logic [63:0] PAT = 64'hA5C3_0F96_3C5A_E1D2;
    localparam logic [7:0] LK = ipr_pkg::OFS_LOCK_CTRL;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack, lock, armed;
    logic [63:0] pins = 64'h0000_0000_0000_0000;
    wire [15:0] outs;
    logic [3:0] sel = 4'hF;
    logic [7:0] codes [16];
    int n_fail = 0;
    int checked = 0;

    always #2.5 clk_i = ~clk_i;

    ipr_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .remappable_pin_i(pins), .remap_lock_o(lock), .unlock_armed_o(armed),
        .ext_irq_one_o(outs[0]), .ext_irq_two_o(outs[1]), .ext_irq_three_o(outs[2]),
        .timer_one_ext_clock_o(outs[3]), .ccp_capture_in_one_o(outs[4]),
        .ccp_capture_in_two_o(outs[5]), .ccp_capture_in_three_o(outs[6]),
        .ccp_capture_in_four_o(outs[7]), .ccp_capture_in_five_o(outs[8]),
        .ccp_capture_in_six_o(outs[9]), .ccp_timer_clk_one_o(outs[10]),
        .ccp_timer_clk_two_o(outs[11]), .ccp_timer_clk_three_o(outs[12]),
        .ccp_timer_clk_four_o(outs[13]), .ccp_timer_clk_five_o(outs[14]),
        .ccp_timer_clk_six_o(outs[15]));

    task automatic report_and_stop();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; ack and data are taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) begin
            chk(32'h0000_0000, 32'h0000_0001);
            report_and_stop();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] q;
        wb(1'b0, a, 16'h0000, q);
        chk(q, {16'h0000, e});
    endtask

    task automatic unlock();
        logic [31:0] q;
        wb(1'b1, ipr_pkg::OFS_UNLOCK_KEY, ipr_pkg::UNLOCK_KEY_FIRST, q);
        wb(1'b1, ipr_pkg::OFS_UNLOCK_KEY, ipr_pkg::UNLOCK_KEY_SECOND, q);
    endtask

    function automatic logic [7:0] ins(input int r);
        return ipr_pkg::OFS_INSEL_BASE + 8'(4 * r);
    endfunction

    function automatic int reg_of(input int i);
        return (i == 0) ? 0 : (i < 3) ? 1 : (i == 3) ? 2 : (i < 10) ? i - 1 : i - 7;
    endfunction

    task automatic t_reset_values();
        for (int r = 0; r < 9; r++) begin
            rd_chk(ins(r), 16'h0000);
        end
        rd_chk(LK, 16'h0000);
        chk({lock, outs}, 17'h0_0000);
    endtask

    // Junk in the unused low bytes of select 0 and 2 must read back as zero
    task automatic t_route();
        logic [15:0] w [9];
        logic [15:0] e;
        logic [31:0] q;
        foreach (w[r]) w[r] = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            w[reg_of(i)] |= (i == 1 || i >= 10) ? {8'h00, codes[i]} : {codes[i], 8'h00};
        end
        for (int r = 0; r < 9; r++) begin
            wb(1'b1, ins(r), w[r] | ((r == 0 || r == 2) ? 16'h00A5 : 16'h0000), q);
            rd_chk(ins(r), w[r]);
        end
        for (int k = 0; k < 2; k++) begin
            pins <= k ? ~PAT : PAT;
            repeat (3) @(posedge clk_i);
            for (int i = 0; i < 16; i++) e[i] = (codes[i] < 8'h40) ? pins[codes[i][5:0]] : 1'b0;
            chk(outs, e);
        end
    endtask

    task automatic t_lock();
        logic [31:0] q;
        wb(1'b1, LK, 16'h0800, q);
        rd_chk(LK, 16'h0000);
        unlock();
        chk(armed, 1'b1);
        // Reads leave the arming alone
        rd_chk(ipr_pkg::OFS_STATUS, 16'h0001);
        wb(1'b1, LK, 16'hFFFF, q);
        chk(armed, 1'b0);
        rd_chk(LK, 16'h0800);
        chk(lock, 1'b1);
        wb(1'b1, ins(3), 16'h1234, q);
        rd_chk(ins(3), {codes[4], codes[10]});
        wb(1'b1, LK, 16'h0000, q);
        rd_chk(LK, 16'h0800);
        rd_chk(8'h14, 16'h0000);
        unlock();
        wb(1'b1, LK, 16'h0000, q);
        rd_chk(LK, 16'h0000);
        wb(1'b1, ins(3), 16'h1234, q);
        rd_chk(ins(3), 16'h1234);
        sel <= 4'h1;
        wb(1'b1, ins(1), 16'hABCD, q);
        sel <= 4'hF;
        rd_chk(ins(1), {codes[2], 8'hCD});
        // A stray write between the keys restarts the sequence
        wb(1'b1, ipr_pkg::OFS_UNLOCK_KEY, ipr_pkg::UNLOCK_KEY_FIRST, q);
        wb(1'b1, ipr_pkg::OFS_UNLOCK_KEY, 16'h0000, q);
        wb(1'b1, ipr_pkg::OFS_UNLOCK_KEY, ipr_pkg::UNLOCK_KEY_SECOND, q);
        chk(armed, 1'b0);
        // Arming lapses if the lock write comes too late
        unlock();
        repeat (40) @(posedge clk_i);
        chk(armed, 1'b0);
        wb(1'b1, LK, 16'h0800, q);
        rd_chk(LK, 16'h0000);
    endtask

    initial begin
        logic [31:0] q;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        for (int i = 0; i < 16; i++) codes[i] = 8'(4 * i + 3);
        t_route();
        for (int i = 0; i < 16; i++) codes[i] = 8'(60 - 4 * i);
        codes[0] = 8'h40;
        codes[1] = 8'hFF;
        t_route();
        t_lock();
        unlock();
        wb(1'b1, LK, 16'h0800, q);
        pins <= 64'h0000_0000_0000_0000;
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        report_and_stop();
    end
endmodule
